// ---- include/mcas_defs.svh ----
// Field positions, reset values and timing counts of the sequencer
`ifndef MCAS_DEFS_SVH
`define MCAS_DEFS_SVH

// ****************************************************************
// Channel function select fields
// ****************************************************************
`define MCAS_MODE_RESET       8'h00
`define MCAS_MODE_TACH_A_BIT  0
`define MCAS_MODE_TACH_B_BIT  1
`define MCAS_MODE_DIODE2_BIT  2
`define MCAS_MODE_VCC5_BIT    3
`define MCAS_MODE_IRQ_A_BIT   4
`define MCAS_MODE_IRQ_B_BIT   5
`define MCAS_MODE_IRQ_C_BIT   6
`define MCAS_MODE_IRQ_SEL_BIT 7

// ****************************************************************
// Converter and timing
// ****************************************************************
`define MCAS_SAR_BITS         8
`define MCAS_NOMINAL_CODE     8'hC0
`define MCAS_SLOT_COUNT       10
`define MCAS_CLK_PERIOD_NS    25
`define MCAS_SLOT_TIME_NS     748000
`define MCAS_DIODE_MEAS_NS    9600000
`define MCAS_DIODE_AVG_N      16

`endif

// ---- include/mcas_pkg.sv ----
// Types shared by the channel configuration and converter sequencer
package mcas_pkg;
`include "mcas_defs.svh"

    typedef enum logic [1:0] {
        MCAS_SEQ_IDLE  = 2'b00,
        MCAS_SEQ_START = 2'b01,
        MCAS_SEQ_CONV  = 2'b10,
        MCAS_SEQ_WAIT  = 2'b11
    } mcas_seq_t;

    typedef enum logic [3:0] {
        MCAS_SLOT_D1    = 4'h0,
        MCAS_SLOT_P5    = 4'h1,
        MCAS_SLOT_P12   = 4'h2,
        MCAS_SLOT_CORE1 = 4'h3,
        MCAS_SLOT_VCC   = 4'h4,
        MCAS_SLOT_AUX_A = 4'h5,
        MCAS_SLOT_AUX_B = 4'h6,
        MCAS_SLOT_P25   = 4'h7,
        MCAS_SLOT_CORE2 = 4'h8,
        MCAS_SLOT_D2    = 4'h9
    } mcas_slot_t;

    typedef struct packed {
        logic       tach_a_en;
        logic       tach_b_en;
        logic       aux_a_en;
        logic       aux_b_en;
        logic       rail_pair_en;
        logic       diode2_en;
        logic       vcc_5v_range;
        logic       irq_mode;
        logic [4:0] irq_en;
    } mcas_pin_cfg_t;

    typedef struct packed {
        logic       busy;
        logic [2:0] bit_idx;
        logic [7:0] code;
        logic [7:0] result;
        logic       done;
    } mcas_sar_st_t;

    typedef struct packed {
        logic [11:0] acc;
        logic [3:0]  count;
        logic [7:0]  avg;
        logic        valid;
    } mcas_avg_st_t;

endpackage

// ---- logic/mcas_sar.sv ----
// Successive-approximation control for the shared 8-bit converter
`timescale 1ns/1ps
module mcas_sar
    import mcas_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_start,
    input  wire logic       i_cmp_hi,
    output logic [7:0]      o_dac_code,
    output logic [7:0]      o_result,
    output logic            o_done
);

    mcas_sar_st_t st_reg;
    mcas_sar_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (i_start) begin
            st_next.busy    = 1'b1;
            st_next.bit_idx = 3'h7;
            st_next.code    = 8'h80;
        end else if (st_reg.busy) begin
            // Trial bit stays only while input is at or above the trial
            if (!i_cmp_hi) begin
                st_next.code[st_reg.bit_idx] = 1'b0;
            end
            if (st_reg.bit_idx != 3'h0) begin
                st_next.code[st_reg.bit_idx - 3'h1] = 1'b1;
                st_next.bit_idx = st_reg.bit_idx - 3'h1;
            end else begin
                st_next.busy   = 1'b0;
                st_next.done   = 1'b1;
                st_next.result = st_next.code;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_dac_code = st_reg.code;
    assign o_result   = st_reg.result;
    assign o_done     = st_reg.done;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_sar_eight_trials: assert property (@(posedge i_ref_clk)
        disable iff (!i_reset_n)
        i_start ##1 !i_start [*8] |=> o_done)
        else $error("conversion did not end after eight trials");

endmodule

// ---- logic/mcas_avg.sv ----
// Sixteen-sample averager for remote diode temperature results
`timescale 1ns/1ps
module mcas_avg
    import mcas_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_clear,
    input  wire logic       i_sample_valid,
    input  wire logic [7:0] i_sample,
    output logic [7:0]      o_avg,
    output logic            o_avg_valid
);

    mcas_avg_st_t st_reg;
    mcas_avg_st_t st_next;
    logic [11:0]  sum;

    always_comb begin
        st_next       = st_reg;
        st_next.valid = 1'b0;
        // Two's-complement sum, sign extended
        sum = st_reg.acc + {{4{i_sample[7]}}, i_sample};
        if (i_clear) begin
            st_next.acc   = '0;
            st_next.count = '0;
        end else if (i_sample_valid) begin
            st_next.count = st_reg.count + 4'h1;
            if (st_reg.count == 4'hF) begin
                st_next.acc   = '0;
                st_next.avg   = sum[11:4];
                st_next.valid = 1'b1;
            end else begin
                st_next.acc = sum;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_avg       = st_reg.avg;
    assign o_avg_valid = st_reg.valid;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_avg_sixteenth: assert property (@(posedge i_ref_clk)
        disable iff (!i_reset_n)
        o_avg_valid |-> $past(st_reg.count) == 4'hF
            && $past(i_sample_valid) && !$past(i_clear))
        else $error("average issued before sixteen samples");

endmodule

// ---- logic/mcas_top.sv ----
// Channel function select and round-robin converter sequencer
`timescale 1ns/1ps
`include "mcas_defs.svh"
module mcas_top
    import mcas_pkg::*;
#(
    parameter int SLOT_CYCLES =
        `MCAS_SLOT_TIME_NS / `MCAS_CLK_PERIOD_NS,
    parameter int DIODE_CONV_CYCLES =
        `MCAS_DIODE_MEAS_NS / (`MCAS_DIODE_AVG_N * `MCAS_CLK_PERIOD_NS)
)
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_mode_wr,
    input  wire logic [7:0] i_mode_wdata,
    input  wire logic       i_start_bit,
    input  wire logic       i_int_clear_bit,
    input  wire logic [1:0] i_cfg2_irq_en,
    input  wire logic [4:0] i_cpu_voltage_id_pins,
    input  wire logic       i_cmp_hi,
    input  wire logic [3:0] i_value_idx,
    output logic [7:0]      o_mode_rdata,
    output mcas_pin_cfg_t   o_pin_cfg,
    output logic [4:0]      o_vid_code,
    output logic [4:0]      o_ext_irq,
    output logic [3:0]      o_mux_sel,
    output logic [7:0]      o_dac_code,
    output logic            o_busy,
    output logic            o_store,
    output logic [7:0]      o_value_rdata
);

    // ****************************************************************
    // State
    // ****************************************************************
    localparam logic [15:0] SLOT_LIM  = 16'(SLOT_CYCLES - 2);
    localparam logic [15:0] DIODE_LIM = 16'(DIODE_CONV_CYCLES - 2);
    localparam logic [3:0]  LAST_REP  = 4'(`MCAS_DIODE_AVG_N - 1);

    typedef struct packed {
        logic [7:0]       mode;
        mcas_pin_cfg_t    cfg;
        mcas_seq_t        seq;
        mcas_slot_t       slot;
        logic [15:0]      timer;
        logic [3:0]       rep;
        logic [9:0][7:0]  values;
        logic [7:0]       rdata;
        logic [4:0]       vid;
        logic [4:0]       irq;
        logic             store;
        logic             busy;
    } mcas_top_st_t;

    mcas_top_st_t st_reg;
    mcas_top_st_t st_next;

    logic       run;
    logic       sar_start;
    logic [7:0] sar_result;
    logic       sar_done;
    logic [7:0] avg_value;
    logic       avg_valid;
    logic       diode_slot;
    logic       avg_clear;

    // ****************************************************************
    // Slot selection
    // ****************************************************************
    function automatic logic slot_enabled(input logic [3:0] s,
                                          input logic [7:0] m);
        logic en;
        en = 1'b0;
        case (s)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: en = 1'b1;
            4'h5: en = m[`MCAS_MODE_TACH_A_BIT];
            4'h6: en = m[`MCAS_MODE_TACH_B_BIT];
            4'h7, 4'h8: en = !m[`MCAS_MODE_DIODE2_BIT];
            4'h9: en = m[`MCAS_MODE_DIODE2_BIT];
            default: en = 1'b0;
        endcase
        return en;
    endfunction

    function automatic logic [3:0] next_slot(input logic [3:0] s,
                                             input logic [7:0] m);
        logic [3:0] cand;
        logic [3:0] pick;
        logic       found;
        cand  = s;
        pick  = 4'h0;
        found = 1'b0;
        for (int i = 0; i < `MCAS_SLOT_COUNT; i++) begin
            cand = (cand == 4'(`MCAS_SLOT_COUNT - 1)) ? 4'h0 : cand + 4'h1;
            if (!found && slot_enabled(cand, m)) begin
                pick  = cand;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    assign run        = i_start_bit && !i_int_clear_bit;
    assign diode_slot = (st_reg.slot == MCAS_SLOT_D1)
                     || (st_reg.slot == MCAS_SLOT_D2);
    assign sar_start  = (st_reg.seq == MCAS_SEQ_START);
    assign avg_clear  = !run || (sar_start && st_reg.rep == 4'h0);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next       = st_reg;
        st_next.store = 1'b0;
        if (i_mode_wr) begin
            st_next.mode = i_mode_wdata;
        end
        st_next.cfg.tach_a_en    = !st_next.mode[`MCAS_MODE_TACH_A_BIT];
        st_next.cfg.aux_a_en     = st_next.mode[`MCAS_MODE_TACH_A_BIT];
        st_next.cfg.tach_b_en    = !st_next.mode[`MCAS_MODE_TACH_B_BIT];
        st_next.cfg.aux_b_en     = st_next.mode[`MCAS_MODE_TACH_B_BIT];
        st_next.cfg.diode2_en    = st_next.mode[`MCAS_MODE_DIODE2_BIT];
        st_next.cfg.rail_pair_en = !st_next.mode[`MCAS_MODE_DIODE2_BIT];
        // Attenuator pick keeps nominal supply at the 3/4-scale code
        st_next.cfg.vcc_5v_range = st_next.mode[`MCAS_MODE_VCC5_BIT];
        st_next.cfg.irq_mode     = st_next.mode[`MCAS_MODE_IRQ_SEL_BIT];
        st_next.cfg.irq_en = {i_cfg2_irq_en[1], i_cfg2_irq_en[0],
                              st_next.mode[`MCAS_MODE_IRQ_C_BIT],
                              st_next.mode[`MCAS_MODE_IRQ_B_BIT],
                              st_next.mode[`MCAS_MODE_IRQ_A_BIT]};
        if (st_reg.cfg.irq_mode) begin
            st_next.vid = 5'h00;
            st_next.irq = i_cpu_voltage_id_pins & st_reg.cfg.irq_en;
        end else begin
            st_next.vid = i_cpu_voltage_id_pins;
            st_next.irq = 5'h00;
        end
        st_next.timer = st_reg.timer + 16'h0001;
        unique case (st_reg.seq)
            MCAS_SEQ_IDLE: begin
                if (run) begin
                    st_next.seq  = MCAS_SEQ_START;
                    st_next.slot = MCAS_SLOT_D1;
                    st_next.rep  = 4'h0;
                end
            end
            MCAS_SEQ_START: begin
                st_next.timer = 16'h0000;
                st_next.seq   = MCAS_SEQ_CONV;
            end
            MCAS_SEQ_CONV: begin
                if (sar_done) begin
                    st_next.seq = MCAS_SEQ_WAIT;
                    if (!diode_slot) begin
                        st_next.values[st_reg.slot] = sar_result;
                        st_next.store = 1'b1;
                    end
                end
            end
            MCAS_SEQ_WAIT: begin
                if (diode_slot && st_reg.timer == DIODE_LIM
                    && st_reg.rep != LAST_REP) begin
                    st_next.rep = st_reg.rep + 4'h1;
                    st_next.seq = MCAS_SEQ_START;
                end else if ((diode_slot && st_reg.timer == DIODE_LIM)
                    || (!diode_slot && st_reg.timer == SLOT_LIM)) begin
                    st_next.rep  = 4'h0;
                    st_next.seq  = MCAS_SEQ_START;
                    st_next.slot = mcas_slot_t'(next_slot(st_reg.slot,
                                                          st_reg.mode));
                end
            end
        endcase
        if (avg_valid) begin
            st_next.values[st_reg.slot] = avg_value;
            st_next.store = 1'b1;
        end
        if (!run) begin
            st_next.seq = MCAS_SEQ_IDLE;
        end
        // Busy kept in a flop so the output is registered
        st_next.busy = (st_next.seq != MCAS_SEQ_IDLE);
        if (i_value_idx < 4'(`MCAS_SLOT_COUNT)) begin
            st_next.rdata = st_reg.values[i_value_idx];
        end else begin
            st_next.rdata = 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg      <= '0;
            st_reg.mode <= `MCAS_MODE_RESET;
            st_reg.cfg  <= '{tach_a_en: 1'b1, tach_b_en: 1'b1,
                             rail_pair_en: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Converter and averager
    // ****************************************************************
    mcas_sar i_mcas_sar (
        .i_ref_clk  (i_ref_clk),
        .i_reset_n  (i_reset_n),
        .i_start    (sar_start),
        .i_cmp_hi   (i_cmp_hi),
        .o_dac_code (o_dac_code),
        .o_result   (sar_result),
        .o_done     (sar_done)
    );

    mcas_avg i_mcas_avg (
        .i_ref_clk      (i_ref_clk),
        .i_reset_n      (i_reset_n),
        .i_clear        (avg_clear),
        .i_sample_valid (sar_done && diode_slot
                         && st_reg.seq == MCAS_SEQ_CONV),
        .i_sample       (sar_result),
        .o_avg          (avg_value),
        .o_avg_valid    (avg_valid)
    );

    assign o_mode_rdata  = st_reg.mode;
    assign o_pin_cfg     = st_reg.cfg;
    assign o_vid_code    = st_reg.vid;
    assign o_ext_irq     = st_reg.irq;
    assign o_mux_sel     = st_reg.slot;
    assign o_busy        = st_reg.busy;
    assign o_store       = st_reg.store;
    assign o_value_rdata = st_reg.rdata;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    a_tach_select: assert property (i_mode_wr |=>
        o_pin_cfg.tach_a_en == !$past(i_mode_wdata[0])
        && o_pin_cfg.aux_b_en == $past(i_mode_wdata[1]))
        else $error("tach or analog pick does not follow mode write");
    a_diode2_select: assert property (i_mode_wr |=>
        o_pin_cfg.diode2_en == $past(i_mode_wdata[2])
        && o_pin_cfg.rail_pair_en == !$past(i_mode_wdata[2]))
        else $error("pin pair pick does not follow mode write");
    a_vcc_range: assert property (i_mode_wr |=>
        o_pin_cfg.vcc_5v_range == $past(i_mode_wdata[3]))
        else $error("supply range does not follow mode write");
    a_irq_a_gate: assert property (o_ext_irq[0] |->
        $past(st_reg.mode[4]) && $past(i_cpu_voltage_id_pins[0]))
        else $error("first interrupt pin passed while disabled");
    a_irq_e_gate: assert property (o_ext_irq[4] |->
        $past(st_reg.cfg.irq_en[4]) && $past(st_reg.cfg.irq_mode))
        else $error("last interrupt pin passed while disabled");
    a_vid_irq_split: assert property ((|o_ext_irq) |->
        o_vid_code == 5'h00 && $past(st_reg.cfg.irq_mode))
        else $error("interrupt inputs active in id mode");
    a_fan_skip: assert property ((o_busy
        && o_mux_sel == MCAS_SLOT_AUX_A) |-> st_reg.mode[0])
        else $error("tach pin converted as analog");
    a_start_run: assert property ((run && !o_busy)
        |=> o_busy && o_mux_sel == MCAS_SLOT_D1)
        else $error("start did not begin at first diode slot");
    a_stop_idle: assert property (!run |=> !o_busy)
        else $error("sequencer kept running after stop");
    a_diode_store: assert property (avg_valid |=> o_store
        && st_reg.values[$past(st_reg.slot)] == $past(avg_value))
        else $error("diode average not stored");
    a_aux_b_skip: assert property ((o_busy
        && o_mux_sel == MCAS_SLOT_AUX_B) |-> st_reg.mode[1])
        else $error("second tach pin converted as analog");
    a_pair_skip: assert property ((o_busy
        && o_mux_sel == MCAS_SLOT_D2) |-> st_reg.mode[2])
        else $error("second diode slot used in rail mode");
    a_store_pulse: assert property (o_store |=> !o_store)
        else $error("store strobe longer than one cycle");

    c_diode1_store: cover property (o_store && o_mux_sel == MCAS_SLOT_D1);
    c_diode2_store: cover property (o_store && o_mux_sel == MCAS_SLOT_D2);
    c_aux_store: cover property (o_store && o_mux_sel == MCAS_SLOT_AUX_B);
    c_wrap: cover property (o_mux_sel == MCAS_SLOT_D1
        && $past(o_mux_sel) != MCAS_SLOT_D1 && o_busy);

endmodule

// ---- verification/mcas_analog_model.sv ----
// Comparator model of the measured inputs behind the shared converter
`timescale 1ns/1ps
module mcas_analog_model
    import mcas_pkg::*;
(
    input  wire logic [3:0]  i_mux_sel,
    input  wire logic [7:0]  i_dac_code,
    input  wire logic [79:0] i_levels,
    output logic             o_cmp_hi
);
    // Scaled input level per slot; codes beyond slot 9 read as ground
    always_comb begin
        o_cmp_hi = 1'b0;
        if (i_mux_sel < 4'hA) begin
            o_cmp_hi = (i_levels[i_mux_sel*8 +: 8] >= i_dac_code);
        end
    end
endmodule

// ---- verification/mcas_top_test.sv ----
// Self-checking bench for the channel configuration and sequencer
`timescale 1ns/1ps
`include "mcas_defs.svh"
module mcas_top_test;
    import mcas_pkg::*;
    localparam int SLOT  = 20;
    localparam int DCONV = 16;
    logic            i_ref_clk = 1'b0;
    logic            i_reset_n = 1'b0;
    logic            i_mode_wr = 1'b0;
    logic [7:0]      i_mode_wdata = 8'h00;
    logic            i_start_bit = 1'b0;
    logic            i_int_clear_bit = 1'b0;
    logic [1:0]      i_cfg2_irq_en = 2'h0;
    logic [4:0]      i_cpu_voltage_id_pins = 5'h00;
    logic [3:0]      i_value_idx = 4'h0;
    logic            cmp_hi;
    logic [7:0]      o_mode_rdata;
    mcas_pin_cfg_t   o_pin_cfg;
    logic [4:0]      o_vid_code;
    logic [4:0]      o_ext_irq;
    logic [3:0]      o_mux_sel;
    logic [7:0]      o_dac_code;
    logic            o_busy;
    logic            o_store;
    logic [7:0]      o_value_rdata;
    logic [9:0][7:0] lvl = '0;
    logic [11:0]     exp_q[$];
    int              failures = 0;
    int              tests_run = 0;
    int              cyc = 0;
    int              run_cyc = 0;
    int              last_cyc = 0;
    int              nstore = 0;
    logic [3:0]      last_slot = 4'h0;
    logic            first = 1'b0;

    always #12.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;

    mcas_top #(.SLOT_CYCLES(SLOT), .DIODE_CONV_CYCLES(DCONV)) i_mcas_top (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata),
        .i_start_bit(i_start_bit), .i_int_clear_bit(i_int_clear_bit),
        .i_cfg2_irq_en(i_cfg2_irq_en),
        .i_cpu_voltage_id_pins(i_cpu_voltage_id_pins),
        .i_cmp_hi(cmp_hi), .i_value_idx(i_value_idx),
        .o_mode_rdata(o_mode_rdata), .o_pin_cfg(o_pin_cfg),
        .o_vid_code(o_vid_code), .o_ext_irq(o_ext_irq),
        .o_mux_sel(o_mux_sel), .o_dac_code(o_dac_code), .o_busy(o_busy),
        .o_store(o_store), .o_value_rdata(o_value_rdata));

    mcas_analog_model i_mcas_analog_model (
        .i_mux_sel(o_mux_sel), .i_dac_code(o_dac_code),
        .i_levels(lvl), .o_cmp_hi(cmp_hi));

    task finish_test;
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task write_mode(input logic [7:0] w);
        @(posedge i_ref_clk);
        i_mode_wr <= 1'b1;
        i_mode_wdata <= w;
        @(posedge i_ref_clk);
        i_mode_wr <= 1'b0;
    endtask

    // ****************************************************************
    // Result watcher: slot order, slot spacing, stored value
    // ****************************************************************
    initial begin : watcher
        logic [11:0] e;
        logic [3:0]  s;
        int          d;
        forever begin
            @(negedge i_ref_clk);
            if (o_store === 1'b1) begin
                s = o_mux_sel;
                d = cyc - (first ? run_cyc : last_cyc);
                nstore++;
                if (exp_q.size() == 0) begin
                    cmp(16'h0, 16'h1, "store with nothing pending");
                end else begin
                    e = exp_q.pop_front();
                    cmp(16'(s), 16'(e[11:8]), "slot order");
                    if (s == MCAS_SLOT_D1 || s == MCAS_SLOT_D2) begin
                        cmp(16'(d >= 245 && d <= 270), 16'h1, "diode time");
                    end else if (last_slot == MCAS_SLOT_D1
                                 || last_slot == MCAS_SLOT_D2) begin
                        cmp(16'(d), 16'(DCONV - 1), "after diode");
                    end else begin
                        cmp(16'(d), 16'(SLOT), "slot spacing");
                    end
                    first = 1'b0;
                    last_cyc = cyc;
                    last_slot = s;
                    @(posedge i_ref_clk);
                    i_value_idx <= s;
                    @(posedge i_ref_clk);
                    @(negedge i_ref_clk);
                    cmp(16'(o_value_rdata), 16'(e[7:0]), "value");
                end
            end
        end
    end

    // ****************************************************************
    // One round-robin pass under a given mode, then stop
    // ****************************************************************
    task run_pass(input logic [7:0] m);
        logic [7:0] v;
        int         n;
        int         k;
        n = 0;
        write_mode(m);
        for (int s = 0; s < 10; s++) begin
            v = 8'($urandom_range(0, 255));
            lvl[s] <= v;
            if (s < 5 || (s == 5 && m[0]) || (s == 6 && m[1]) ||
                ((s == 7 || s == 8) && !m[2]) || (s == 9 && m[2])) begin
                exp_q.push_back({4'(s), v});
                n++;
            end
        end
        @(posedge i_ref_clk);
        i_int_clear_bit <= 1'b1;
        i_start_bit <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        cmp(16'(o_busy), 16'h0, "gated by interrupt clear");
        @(posedge i_ref_clk);
        i_int_clear_bit <= 1'b0;
        run_cyc = cyc;
        first = 1'b1;
        n = n + nstore;
        k = 0;
        while (nstore < n && k < 3000) begin
            @(posedge i_ref_clk);
            k++;
        end
        if (k >= 3000) begin
            failures++;
            finish_test();
        end
        i_start_bit <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        cmp(16'(o_busy), 16'h0, "stops on start clear");
        cmp(16'(exp_q.size()), 16'h0, "pending results");
    endtask

    initial begin : driver
        logic [7:0]  w;
        logic [1:0]  c2;
        logic [4:0]  p;
        logic [12:0] ec;
        void'($urandom(32'hD7E4));
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        @(negedge i_ref_clk);
        cmp(16'(o_mode_rdata), 16'(`MCAS_MODE_RESET), "mode reset");
        cmp(16'(o_pin_cfg), 16'({5'b11001, 8'h00}), "cfg reset");
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom());
            c2 = 2'($urandom());
            p = 5'($urandom());
            @(posedge i_ref_clk);
            i_cfg2_irq_en <= c2;
            i_cpu_voltage_id_pins <= p;
            write_mode(w);
            repeat (2) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            ec = {~w[0], ~w[1], w[0], w[1], ~w[2], w[2], w[3], w[7],
                  c2, w[6:4]};
            cmp(16'(o_mode_rdata), 16'(w), "mode readback");
            cmp(16'(o_pin_cfg), 16'(ec), "pin use");
            cmp(16'(o_vid_code), 16'(w[7] ? 5'h00 : p), "id pins");
            cmp(16'(o_ext_irq), 16'(w[7] ? (p & ec[4:0]) : 5'h00),
                "irq pins");
        end
        run_pass(8'h00);
        run_pass({5'($urandom()), 3'b111});
        run_pass({5'($urandom()), 3'b010});
        finish_test();
    end
endmodule
